// ### rtl/blbh_top.sv
// Overview of operation
// - Boot space is 16K bytes split into eight 2K-byte pages.
// - Boot bytes are read singly and packed into 24-bit program words.
// - A three-bit page field in system control picks the boot page.
// - Writing the force-boot bit starts a boot sequence.
// - Reset release with memory map select low boots page 0 automatically.
// - Boot reads insert zero to seven wait states, three after reset.
// - Boot reads use boot space select and read strobe.
// - Boot bytes come only from data lines 8 to 15.
// - Page number drives two top data lines and top address line.
// - Bus request during boot is granted after the current byte completes.
// - Idle bus: next cycle float pins, assert grant, halt execution.
// - Continue mode keeps execution running while granted; external accesses wait for release.
// - During an access, grant waits until the cycle after it ends.
// - Grant may fall between two external accesses of one instruction.
// - Request release drops grant, re-drives pins, resumes execution.
// - Request and grant work in every state, reset included.
// - Automatic boot only with no pending request and map select low.
// - After boot the first fetch is from program address zero.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "blbh_regs.svh"
module blbh_top #(
  parameter int BOOT_WORDS = 512,
  parameter int PM_AW = 9
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Register port
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  // External bus pins
  output logic [13:0] ADDR_O,
  output logic ADDR_OE_N_O,
  input wire logic [23:0] DATA_I,
  output logic [23:0] DATA_O,
  output logic [23:0] DATA_OE_N_O,
  output logic BOOT_SPACE_SELECT_N_O,
  output logic PROGRAM_SPACE_SELECT_N_O,
  output logic DATA_SPACE_SELECT_N_O,
  output logic RD_N_O,
  output logic WR_N_O,
  output logic STROBE_OE_N_O,
  // Bus handoff and strap
  input wire logic BUS_REQUEST_N_I,
  output logic BUS_GRANT_N_O,
  input wire logic MEMORY_MAP_SELECT_I,
  // Core external access port
  input wire logic CORE_EXT_REQ_I,
  input wire logic CORE_EXT_WRITE_I,
  input wire logic CORE_EXT_PM_I,
  input wire logic [13:0] CORE_EXT_ADDR_I,
  input wire logic [23:0] CORE_EXT_WDATA_I,
  input wire blbh_pkg::blbh_wait_t CORE_EXT_WAITS_I,
  output logic CORE_EXT_ACK_O,
  output logic [23:0] CORE_EXT_RDATA_O,
  // Core run control
  output logic CORE_RUN_O,
  output logic CORE_RESTART_O,
  output logic [13:0] CORE_START_ADDR_O,
  // Program memory load port
  output logic PM_WE_O,
  output logic [PM_AW-1:0] PM_ADDR_O,
  output logic [23:0] PM_WDATA_O
);
  import blbh_pkg::*;

  localparam int BOOT_BYTES = 3 * BOOT_WORDS;

  generate
    if (BOOT_BYTES > `BLBH_PAGE_BYTES || BOOT_WORDS > (1 << PM_AW) || BOOT_WORDS < 1) begin : g_chk
      $error("BOOT_WORDS does not fit a boot page or program memory");
    end
  endgenerate

  function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  // Control and sequencing state
  blbh_state_t state_q, state_d;
  logic acc_boot_q, acc_boot_d;
  blbh_wait_t wait_q, wait_d;
  logic booting_q, booting_d;
  blbh_page_t boot_page_q, boot_page_d;
  logic [10:0] byte_cnt_q, byte_cnt_d;
  logic [PM_AW-1:0] word_cnt_q, word_cnt_d;
  logic first_q, first_d;
  logic arm_q, arm_d;
  logic force_q, force_d;
  blbh_page_t page_q, page_d;
  blbh_wait_t bwait_q, bwait_d;
  logic go_q, go_d;
  logic grant_q, grant_d;
  logic [15:0] rdata_q, rdata_d;
  // Pin and answer state
  logic [13:0] addr_q, addr_d;
  logic [23:0] dout_q, dout_d;
  logic [23:0] doe_n_q, doe_n_d;
  logic bms_n_q, bms_n_d, pms_n_q, pms_n_d, dms_n_q, dms_n_d;
  logic rd_n_q, rd_n_d, wr_n_q, wr_n_d;
  logic ack_q, ack_d;
  logic [23:0] crdata_q, crdata_d;
  logic restart_q, restart_d;

  logic byte_valid, clear_pack, word_valid, grant_eff, wr_ctl;
  logic [23:0] word;

  assign wr_ctl = REG_WR_I && reg_hit(REG_ADDR_I, `BLBH_SYSCTL_OFS);

  blbh_byte_packer #(
    .WORD_BYTES(3)
  ) u_packer (
    .CLK_I(CLK_I),
    .RESETN_I(RESETN_I),
    .clear_i(clear_pack),
    .byte_valid_i(byte_valid),
    .byte_i(DATA_I[`BLBH_BOOT_BYTE_LSB +: 8]),
    .word_valid_o(word_valid),
    .word_o(word)
  );

  always_comb begin
    state_d = state_q;
    acc_boot_d = acc_boot_q;
    wait_d = wait_q;
    booting_d = booting_q;
    boot_page_d = boot_page_q;
    byte_cnt_d = byte_cnt_q;
    word_cnt_d = word_cnt_q;
    first_d = 1'b0;
    arm_d = arm_q;
    force_d = force_q;
    page_d = page_q;
    bwait_d = bwait_q;
    go_d = go_q;
    grant_d = grant_q;
    addr_d = addr_q;
    dout_d = dout_q;
    doe_n_d = doe_n_q;
    bms_n_d = bms_n_q;
    pms_n_d = pms_n_q;
    dms_n_d = dms_n_q;
    rd_n_d = rd_n_q;
    wr_n_d = wr_n_q;
    ack_d = 1'b0;
    crdata_d = crdata_q;
    restart_d = 1'b0;
    byte_valid = 1'b0;
    clear_pack = 1'b0;
    if (first_q && !MEMORY_MAP_SELECT_I) begin
      arm_d = 1'b1;
    end
    if (word_valid) begin
      word_cnt_d = word_cnt_q + PM_AW'(1);
      if (word_cnt_q == PM_AW'(BOOT_WORDS - 1)) begin
        booting_d = 1'b0;
        restart_d = 1'b1;
      end
    end
    case (state_q)
      ST_IDLE: begin
        if (!BUS_REQUEST_N_I) begin
          state_d = ST_GRANT;
          grant_d = 1'b1;
        end else if ((arm_q || force_q) && !booting_q) begin
          booting_d = 1'b1;
          boot_page_d = arm_q ? `BLBH_AUTO_PAGE : page_q;
          arm_d = 1'b0;
          force_d = arm_q ? force_q : 1'b0;
          byte_cnt_d = '0;
          word_cnt_d = '0;
          clear_pack = 1'b1;
        end else if (booting_q && byte_cnt_q < 11'(BOOT_BYTES)) begin
          state_d = ST_ACCESS;
          acc_boot_d = 1'b1;
          wait_d = bwait_q;
          addr_d = {boot_page_q[0], 2'b00, byte_cnt_q};
          dout_d = {boot_page_q[2:1], 22'h000000};
          doe_n_d = {2'b00, 22'h3FFFFF};
          bms_n_d = 1'b0;
          rd_n_d = 1'b0;
        end else if (CORE_EXT_REQ_I && !booting_q && !ack_q) begin
          state_d = ST_ACCESS;
          acc_boot_d = 1'b0;
          wait_d = CORE_EXT_WAITS_I;
          addr_d = CORE_EXT_ADDR_I;
          dout_d = CORE_EXT_WDATA_I;
          doe_n_d = CORE_EXT_WRITE_I ? 24'h000000 : 24'hFFFFFF;
          pms_n_d = !CORE_EXT_PM_I;
          dms_n_d = CORE_EXT_PM_I;
          rd_n_d = CORE_EXT_WRITE_I;
          wr_n_d = !CORE_EXT_WRITE_I;
        end
      end
      ST_ACCESS: begin
        if (wait_q == 3'h0) begin
          state_d = ST_IDLE;
          bms_n_d = 1'b1;
          pms_n_d = 1'b1;
          dms_n_d = 1'b1;
          rd_n_d = 1'b1;
          wr_n_d = 1'b1;
          doe_n_d = 24'hFFFFFF;
          if (acc_boot_q) begin
            byte_valid = 1'b1;
            byte_cnt_d = byte_cnt_q + 11'h001;
          end else begin
            ack_d = 1'b1;
            crdata_d = DATA_I;
          end
        end else begin
          wait_d = wait_q - 3'h1;
        end
      end
      ST_GRANT: begin
        if (BUS_REQUEST_N_I) begin
          state_d = ST_IDLE;
          grant_d = 1'b0;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (wr_ctl) begin
      page_d = REG_WDATA_I[`BLBH_PAGE_LSB +: 3];
      bwait_d = REG_WDATA_I[`BLBH_BWAIT_LSB +: 3];
      go_d = REG_WDATA_I[`BLBH_GO_BIT];
      if (REG_WDATA_I[`BLBH_FORCE_BIT]) begin
        force_d = 1'b1;
      end
    end
    rdata_d = 16'h0000;
    if (REG_RD_I && reg_hit(REG_ADDR_I, `BLBH_SYSCTL_OFS)) begin
      rdata_d[`BLBH_PAGE_LSB +: 3] = page_q;
      rdata_d[`BLBH_BWAIT_LSB +: 3] = bwait_q;
      rdata_d[`BLBH_GO_BIT] = go_q;
    end else if (REG_RD_I && reg_hit(REG_ADDR_I, `BLBH_STATUS_OFS)) begin
      rdata_d[`BLBH_ST_BOOTING_BIT] = booting_q;
      rdata_d[`BLBH_ST_GRANTED_BIT] = grant_q;
      rdata_d[`BLBH_ST_HALTED_BIT] = !CORE_RUN_O;
      rdata_d[`BLBH_ST_ARMED_BIT] = arm_q || force_q;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_q <= ST_IDLE;
      acc_boot_q <= 1'b0;
      wait_q <= 3'h0;
      booting_q <= 1'b0;
      boot_page_q <= `BLBH_PAGE_RST;
      byte_cnt_q <= 11'h000;
      word_cnt_q <= '0;
      first_q <= 1'b1;
      arm_q <= 1'b0;
      force_q <= 1'b0;
      page_q <= `BLBH_PAGE_RST;
      bwait_q <= `BLBH_BWAIT_RST;
      go_q <= 1'b0;
      grant_q <= 1'b0;
      rdata_q <= 16'h0000;
      addr_q <= 14'h0000;
      dout_q <= 24'h000000;
      doe_n_q <= 24'hFFFFFF;
      bms_n_q <= 1'b1;
      pms_n_q <= 1'b1;
      dms_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      ack_q <= 1'b0;
      crdata_q <= 24'h000000;
      restart_q <= 1'b0;
    end else begin
      state_q <= state_d;
      acc_boot_q <= acc_boot_d;
      wait_q <= wait_d;
      booting_q <= booting_d;
      boot_page_q <= boot_page_d;
      byte_cnt_q <= byte_cnt_d;
      word_cnt_q <= word_cnt_d;
      first_q <= first_d;
      arm_q <= arm_d;
      force_q <= force_d;
      page_q <= page_d;
      bwait_q <= bwait_d;
      go_q <= go_d;
      grant_q <= grant_d;
      rdata_q <= rdata_d;
      addr_q <= addr_d;
      dout_q <= dout_d;
      doe_n_q <= doe_n_d;
      bms_n_q <= bms_n_d;
      pms_n_q <= pms_n_d;
      dms_n_q <= dms_n_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      ack_q <= ack_d;
      crdata_q <= crdata_d;
      restart_q <= restart_d;
    end
  end

  // Grant follows the request directly in reset and in the cycle after it, so no bus fight
  assign grant_eff = grant_q || (first_q && !BUS_REQUEST_N_I);
  assign BUS_GRANT_N_O = !grant_eff;
  assign ADDR_OE_N_O = grant_eff;
  assign STROBE_OE_N_O = grant_eff;
  assign DATA_OE_N_O = grant_eff ? 24'hFFFFFF : doe_n_q;
  assign ADDR_O = addr_q;
  assign DATA_O = dout_q;
  assign BOOT_SPACE_SELECT_N_O = bms_n_q;
  assign PROGRAM_SPACE_SELECT_N_O = pms_n_q;
  assign DATA_SPACE_SELECT_N_O = dms_n_q;
  assign RD_N_O = rd_n_q;
  assign WR_N_O = wr_n_q;
  assign REG_RDATA_O = rdata_q;
  assign CORE_EXT_ACK_O = ack_q;
  assign CORE_EXT_RDATA_O = crdata_q;
  assign CORE_RESTART_O = restart_q;
  assign CORE_START_ADDR_O = `BLBH_RESTART_ADDR;
  // Halt while booting, and while granted unless continue mode is set
  assign CORE_RUN_O = RESETN_I && !booting_q && !(grant_eff && !go_q);
  assign PM_WE_O = word_valid;
  assign PM_WDATA_O = word;
  assign PM_ADDR_O = word_cnt_q;

  a_grant_next_cycle: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (state_q == ST_IDLE && !BUS_REQUEST_N_I) |=> (!BUS_GRANT_N_O && ADDR_OE_N_O
      && STROBE_OE_N_O && DATA_OE_N_O == 24'hFFFFFF))
    else $error("grant did not follow an idle request");

  a_grant_after_access: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (state_q == ST_ACCESS) |-> BUS_GRANT_N_O)
    else $error("grant given during an access");

  a_grant_release: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (grant_q && BUS_REQUEST_N_I) |=> (BUS_GRANT_N_O && !ADDR_OE_N_O && !STROBE_OE_N_O))
    else $error("grant not released after request release");

  a_grant_in_reset: assert property (@(posedge CLK_I)
    !RESETN_I |-> (BUS_GRANT_N_O == BUS_REQUEST_N_I))
    else $error("handoff not working under reset");

  a_boot_lanes: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (!BOOT_SPACE_SELECT_N_O && !grant_q) |-> (DATA_OE_N_O == {2'b00, 22'h3FFFFF}
      && DATA_O[23:22] == boot_page_q[2:1] && ADDR_O[13] == boot_page_q[0] && !RD_N_O))
    else $error("boot address or data lanes wrong");

  a_boot_wait_three: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    ($fell(BOOT_SPACE_SELECT_N_O) && bwait_q == 3'h3)
      |-> (!BOOT_SPACE_SELECT_N_O)[*4] ##1 BOOT_SPACE_SELECT_N_O)
    else $error("boot strobe length wrong for three waits");

  a_halt_granted: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (!BUS_GRANT_N_O && !booting_q) |-> (CORE_RUN_O == go_q))
    else $error("run state wrong while granted");

  a_boot_restart: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (word_valid && word_cnt_q == PM_AW'(BOOT_WORDS - 1))
      |=> (CORE_RESTART_O && !booting_q && CORE_START_ADDR_O == 14'h0000))
    else $error("no restart from address zero after boot");

  a_auto_boot: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (arm_q && state_q == ST_IDLE && BUS_REQUEST_N_I && !booting_q)
      |=> (booting_q && boot_page_q == 3'h0))
    else $error("automatic boot did not start on page zero");

endmodule : blbh_top

// ### rtl/blbh_regs.svh
`ifndef BLBH_REGS_SVH
`define BLBH_REGS_SVH

// Register offsets
`define BLBH_SYSCTL_OFS 4'h0
`define BLBH_STATUS_OFS 4'h1

// System control fields
`define BLBH_PAGE_LSB 0
`define BLBH_FORCE_BIT 3
`define BLBH_BWAIT_LSB 4
`define BLBH_GO_BIT 7

// Status fields
`define BLBH_ST_BOOTING_BIT 0
`define BLBH_ST_GRANTED_BIT 1
`define BLBH_ST_HALTED_BIT 2
`define BLBH_ST_ARMED_BIT 3

// Reset values
`define BLBH_BWAIT_RST 3'h3
`define BLBH_PAGE_RST 3'h0
`define BLBH_AUTO_PAGE 3'h0
`define BLBH_RESTART_ADDR 14'h0000

// Boot space layout
`define BLBH_PAGE_BYTES 2048
`define BLBH_BOOT_BYTE_LSB 8

`endif

// ### rtl/blbh_pkg.sv
package blbh_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_GRANT
  } blbh_state_t;

  typedef logic [2:0] blbh_page_t;
  typedef logic [2:0] blbh_wait_t;

endpackage : blbh_pkg

// ### rtl/blbh_byte_packer.sv
`timescale 1ns/1ps
module blbh_byte_packer #(
  parameter int WORD_BYTES = 3
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Byte stream
  input wire logic clear_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  // Packed word
  output logic word_valid_o,
  output logic [8*WORD_BYTES-1:0] word_o
);
  import blbh_pkg::*;

  localparam int CW = $clog2(WORD_BYTES);

  logic [7:0] lane_q [WORD_BYTES];
  logic [7:0] lane_d [WORD_BYTES];
  logic [8*WORD_BYTES-1:0] shifted;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [8*WORD_BYTES-1:0] word_q, word_d;
  logic valid_q, valid_d;

  generate
    if (WORD_BYTES < 2) begin : g_chk
      $error("WORD_BYTES must be at least 2");
    end
    for (genvar k = 0; k < WORD_BYTES; k++) begin : g_lane
      // First byte ends up in the top lane
      if (k == 0) begin : g_first
        assign lane_d[k] = byte_valid_i ? byte_i : lane_q[k];
      end else begin : g_rest
        assign lane_d[k] = byte_valid_i ? lane_q[k-1] : lane_q[k];
      end
      assign shifted[8*k+7:8*k] = lane_d[k];
      always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          lane_q[k] <= 8'h00;
        end else begin
          lane_q[k] <= lane_d[k];
        end
      end
    end
  endgenerate

  always_comb begin
    cnt_d = cnt_q;
    word_d = word_q;
    valid_d = 1'b0;
    if (clear_i) begin
      cnt_d = '0;
    end else if (byte_valid_i) begin
      if (cnt_q == CW'(WORD_BYTES - 1)) begin
        cnt_d = '0;
        word_d = shifted;
        valid_d = 1'b1;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cnt_q <= '0;
      word_q <= '0;
      valid_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      word_q <= word_d;
      valid_q <= valid_d;
    end
  end

  assign word_valid_o = valid_q;
  assign word_o = word_q;

endmodule : blbh_byte_packer

// ### tb/blbh_boot_mem.sv
`timescale 1ns/1ps
module blbh_boot_mem (
  // Clock
  input wire logic clk_i,
  // Boot pins as seen on the board
  input wire logic [13:0] addr_i,
  input wire logic [1:0] page_hi_i,
  input wire logic sel_n_i,
  input wire logic rd_n_i,
  // Data bus drive
  output logic [23:0] data_o
);
  logic [23:0] junk_q = 24'hA5C396;

  function automatic logic [7:0] byte_at(input logic [2:0] pg, input logic [10:0] ofs);
    return ofs[7:0] ^ {pg, 5'h0B};
  endfunction : byte_at

  // Undriven lines change every cycle so stale data never passes
  always @(posedge clk_i) begin
    junk_q <= ~junk_q;
  end

  // Byte on the middle lane while selected and read, paged by top lines
  always_comb begin
    data_o = junk_q;
    if (!sel_n_i && !rd_n_i) begin
      data_o[15:8] = byte_at({page_hi_i, addr_i[13]}, addr_i[10:0]);
    end
  end
endmodule : blbh_boot_mem

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import blbh_pkg::*;
  localparam int NW = 2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] ra = 4'h0;
  logic [15:0] rw = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rq;
  logic [13:0] addr;
  logic aoe;
  logic [23:0] din;
  logic [23:0] dout;
  logic [23:0] doe;
  logic [23:0] mem;
  logic boot_space_select_n;
  logic program_space_select_n;
  logic data_space_select_n;
  logic rdn;
  logic wrn;
  logic xwr = 1'b0;
  logic [23:0] crd;
  logic soe;
  logic br_n = 1'b1;
  logic bg_n;
  logic memory_map_select = 1'b1;
  logic xreq = 1'b0;
  logic xpm = 1'b0;
  blbh_wait_t xws = 3'h0;
  logic ack;
  logic run;
  logic rst_pulse;
  logic [13:0] sadr;
  logic pwe;
  logic [8:0] padr;
  logic [23:0] pdat;
  int err_total = 0;
  int comparisons = 0;
  int rl = 0;
  int ll = 0;
  logic [2:0] spg;
  logic [3:0] soes;
  logic [32:0] pq[$];

  assign din = (doe & mem) | (~doe & dout);
  always #2.5 clk = ~clk;

  blbh_top #(.BOOT_WORDS(NW), .PM_AW(9)) blbh_top_i (.CLK_I(clk), .RESETN_I(rst_n),
    .REG_ADDR_I(ra), .REG_WDATA_I(rw), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rq),
    .ADDR_O(addr), .ADDR_OE_N_O(aoe), .DATA_I(din), .DATA_O(dout), .DATA_OE_N_O(doe),
    .BOOT_SPACE_SELECT_N_O(boot_space_select_n), .PROGRAM_SPACE_SELECT_N_O(program_space_select_n),
    .DATA_SPACE_SELECT_N_O(data_space_select_n), .RD_N_O(rdn), .WR_N_O(wrn), .STROBE_OE_N_O(soe),
    .BUS_REQUEST_N_I(br_n), .BUS_GRANT_N_O(bg_n), .MEMORY_MAP_SELECT_I(memory_map_select),
    .CORE_EXT_REQ_I(xreq), .CORE_EXT_WRITE_I(xwr), .CORE_EXT_PM_I(xpm),
    .CORE_EXT_ADDR_I(14'h0123), .CORE_EXT_WDATA_I(24'h5A5A5A), .CORE_EXT_WAITS_I(xws),
    .CORE_EXT_ACK_O(ack), .CORE_EXT_RDATA_O(crd), .CORE_RUN_O(run),
    .CORE_RESTART_O(rst_pulse), .CORE_START_ADDR_O(sadr), .PM_WE_O(pwe),
    .PM_ADDR_O(padr), .PM_WDATA_O(pdat));

  blbh_boot_mem mem_i (.clk_i(clk), .addr_i(addr), .page_hi_i(din[23:22]),
    .sel_n_i(boot_space_select_n | soe), .rd_n_i(rdn | soe), .data_o(mem));

  // Collects program words and boot strobe shape
  always @(posedge clk) begin
    if (pwe === 1'b1) begin
      pq.push_back({padr, pdat});
    end
    if (boot_space_select_n === 1'b0 && soe === 1'b0) begin
      rl++;
      spg = {dout[23:22], addr[13]};
      soes = {doe[23:22], &doe[15:8], rdn};
    end else if (rl != 0) begin
      ll = rl;
      rl = 0;
    end
  end

  task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic results();
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    ra <= a;
    rw <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    ra <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rq;
  endtask : reg_read

  task automatic do_reset(input logic mm, input logic br);
    @(posedge clk);
    rst_n <= 1'b0;
    memory_map_select <= mm;
    br_n <= br;
    repeat (5) @(posedge clk);
    chk("grant in reset", bg_n, br);
    ll = 0;
    pq.delete();
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic wait_boot(input logic [2:0] pg, input int ws);
    int i;
    i = 0;
    while (rst_pulse !== 1'b1 && i < 3000) begin
      @(posedge clk);
      i++;
    end
    chk("boot finished", i < 3000, 1'b1);
    #1 chk("run after boot", run, 1'b1);
    chk("start address", sadr, 14'h0000);
    chk("word count", pq.size(), NW);
    for (i = 0; i < NW; i++) begin
      chk("boot word", pq[i], {i[8:0], mem_i.byte_at(pg, 11'(3 * i)),
        mem_i.byte_at(pg, 11'(3 * i + 1)), mem_i.byte_at(pg, 11'(3 * i + 2))});
    end
    chk("strobe length", ll, ws + 1);
    chk("page pins", {spg, soes}, {pg, 4'b0010});
  endtask : wait_boot

  task automatic t_no_boot();
    do_reset(1'b1, 1'b1);
    repeat (60) @(posedge clk);
    chk("words without boot", pq.size() + ll, 0);
  endtask : t_no_boot

  task automatic t_auto_boot();
    do_reset(1'b0, 1'b1);
    wait_boot(3'h0, 3);
  endtask : t_auto_boot

  task automatic t_force();
    logic [15:0] d;
    pq.delete();
    reg_write(4'h0, 16'h000D);
    reg_read(4'h0, d);
    chk("control readback", d, 16'h0005);
    reg_read(4'h1, d);
    chk("booting flag", d[0], 1'b1);
    wait_boot(3'h5, 0);
    reg_read(4'hF, d);
    chk("unmapped read", d, 16'h0000);
  endtask : t_force

  task automatic t_grant_idle();
    logic [15:0] d;
    reg_write(4'h0, 16'h0030);
    br_n <= 1'b0;
    @(posedge clk);
    #1 chk("idle grant", {bg_n, aoe, soe, doe, run}, {3'b011, 24'hFFFFFF, 1'b0});
    reg_read(4'h1, d);
    chk("status while granted", d[3:0], 4'b0110);
    reg_write(4'h0, 16'h00B0);
    #1 chk("continue mode", run, 1'b1);
    @(posedge clk);
    br_n <= 1'b1;
    @(posedge clk);
    #1 chk("release", {bg_n, aoe, soe}, 3'b100);
  endtask : t_grant_idle

  task automatic t_boot_grant();
    int i;
    pq.delete();
    reg_write(4'h0, 16'h003A);
    for (i = 0; boot_space_select_n !== 1'b0 && i < 100; i++) @(posedge clk);
    br_n <= 1'b0;
    for (i = 0; bg_n !== 1'b0 && i < 100; i++) @(posedge clk);
    #1 chk("grant after byte", {soe, 4'(ll)}, {1'b1, 4'h4});
    repeat (10) @(posedge clk);
    br_n <= 1'b1;
    wait_boot(3'h2, 3);
  endtask : t_boot_grant

  task automatic t_core_grant();
    int n;
    int na;
    int ng;
    logic [23:0] m;
    na = 0;
    ng = 0;
    m = 24'h000000;
    @(posedge clk);
    xws <= 3'h2;
    xpm <= 1'b1;
    xreq <= 1'b1;
    @(posedge clk);
    br_n <= 1'b0;
    for (n = 1; n <= 20; n++) begin
      @(posedge clk);
      if (na != 0) xreq <= 1'b0;
      #1;
      if (n == 1) chk("core strobes", {program_space_select_n, data_space_select_n, rdn, wrn, addr}, {4'b0101, 14'h0123});
      if (n == 2) m = din;
      if (ack === 1'b1 && na == 0) begin
        na = n;
        chk("core read data", crd, m);
      end
      if (bg_n === 1'b0 && ng == 0) ng = n;
    end
    chk("ack delay", na, 3);
    chk("grant after access", ng, 4);
    @(posedge clk);
    br_n <= 1'b1;
    xpm <= 1'b0;
    xws <= 3'h0;
    repeat (3) @(posedge clk);
    xwr <= 1'b1;
    xreq <= 1'b1;
    @(posedge clk);
    #1 chk("core write strobes", {program_space_select_n, data_space_select_n, rdn, wrn, doe}, {4'b1010, 24'h000000});
    chk("core write data", dout, 24'h5A5A5A);
    @(posedge clk);
    xreq <= 1'b0;
    xwr <= 1'b0;
    #1 chk("write ack", ack, 1'b1);
  endtask : t_core_grant

  task automatic t_reset_request();
    do_reset(1'b0, 1'b0);
    repeat (20) @(posedge clk);
    chk("boot held by request", {pq.size(), bg_n}, 0);
    br_n <= 1'b1;
    wait_boot(3'h0, 3);
  endtask : t_reset_request

  initial begin
    t_no_boot();
    t_auto_boot();
    t_force();
    t_grant_idle();
    t_boot_grant();
    t_core_grant();
    t_reset_request();
    results();
  end

  initial begin
    #100000;
    err_total++;
    results();
  end
endmodule : testbench
